/* design/ecpt_consts.svh */
`ifndef ECPT_CONSTS_SVH
`define ECPT_CONSTS_SVH
// Register byte offsets
`define ECPT_CTL0_OFS    8'h00
`define ECPT_CTL1_OFS    8'h04
`define ECPT_IOC2_OFS    8'h08
`define ECPT_OPT0_OFS    8'h0c
`define ECPT_CCR0_OFS    8'h10
`define ECPT_CCR1_OFS    8'h14
`define ECPT_CNT_OFS     8'h18
`define ECPT_STAT_OFS    8'h1c
// Field positions
`define ECPT_CE_BIT      0
`define ECPT_EST_BIT     6
`define ECPT_EEE_BIT     5
`define ECPT_OVF_BIT     0
// Mode codes and values
`define ECPT_MODE_INTV   3'h0
`define ECPT_MODE_EVENT  3'h1
`define ECPT_MODE_TRIG   3'h2
`define ECPT_CNT_MAX     16'hffff
`define ECPT_CNT_ZERO    16'h0000
`define ECPT_IOC2_MASK   8'h0f
`define ECPT_CCR_RST     16'h0000
`endif

/* design/ecpt_pkg.sv */
`default_nettype none
package ecpt_pkg;
    typedef enum logic [2:0] {
        ECPT_IDLE = 3'b001,
        ECPT_WAIT = 3'b010,
        ECPT_RUN  = 3'b100
    } ecpt_state_t;
endpackage : ecpt_pkg
`default_nettype wire

/* design/ecpt_timer.sv */
// Overview of operation
// RULE1 - Mode 001 counts valid event-input edges instead of count clocks.
// RULE2 - Event mode: counter clears and match-zero irq after compare-zero plus one edges.
// RULE3 - Software never programs compare zero to zero in event mode.
// RULE4 - Outputs unused in event mode; interval mode plus event clock select instead.
// RULE5 - Compare zero FFFFH: wrap to zero, irq, no overflow flag.
// RULE6 - Event mode compare-zero write reaches buffer at once; may wrap first.
// RULE7 - Software should stop counter before lowering compare zero.
// RULE8 - Match-one irq once per cycle if below compare zero, never if above.
// RULE9 - Mode 010 is triggered pulse, waits for trigger after count enable.
// RULE10 - Software uses internal clock, event clock select zero, in triggered mode.
// RULE11 - Trigger clears counter FFFFH to 0000H and starts PWM on output one.
// RULE12 - Retrigger while running clears counter, inverts output zero, forces output one high. Code drives it high only when buffered compare one is nonzero.
// RULE13 - Trigger is trigger-input valid edge or software trigger bit write.
// RULE14 - Period is compare zero plus one clocks, active width compare one clocks.
// RULE15 - With software trigger, output zero toggles once per PWM period.
// RULE16 - Match-zero irq on count after buffer match with clear; match-one on match.
// RULE17 - Buffers reload only on clear after match, and only after compare one written.
// RULE18 - Software writes compare zero first, compare one last.
// RULE19 - Software waits for match-zero irq before writing compares again.
// RULE20 - Compare one zero gives constant inactive output; irq still fires.
// RULE21 - Compare one equal compare zero plus one gives constant active output.
// RULE22 - Trigger just after match-one clears counter and asserts output one.
// RULE23 - Trigger just before match-one suppresses irq, keeps output one active.
// RULE24 - Edge select: event edge bits 3:2, trigger edge bits 1:0, 7:4 zero.
// RULE25 - Live counter readable at any time through readback register.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`include "ecpt_consts.svh"
`default_nettype none
module ecpt_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // External pins
    input  wire logic        event_in,
    input  wire logic        trigger_in,
    output logic             timer_output_zero,
    output logic             timer_output_one,
    output logic             match_zero_irq,
    output logic             match_one_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic was);
        // 00 none, 01 rising, 10 falling, 11 both
        edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
    endfunction : edge_hit

    // ----------------------------------------
    // Bus and register state
    // ----------------------------------------
    logic        wr_pend_q, wr_pend_d;
    logic [7:0]  wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        ce_q, ce_d;
    logic [2:0]  mode_q, mode_d;
    logic        eee_q, eee_d;
    logic [7:0]  ioc2_q, ioc2_d;
    logic        ovf_q, ovf_d;
    logic [15:0] ccr0_q, ccr0_d;
    logic [15:0] ccr1_q, ccr1_d;
    logic [15:0] buf0_q, buf0_d;
    logic [15:0] buf1_q, buf1_d;
    logic        reload_q, reload_d;
    logic        swtrig_q, swtrig_d;
    logic [15:0] cnt_q, cnt_d;
    logic        evt_q, evt_d;
    logic        trg_q, trg_d;
    logic        to0_q, to0_d;
    logic        to1_q, to1_d;
    logic        irq0_q, irq0_d;
    logic        irq1_q, irq1_d;
    ecpt_pkg::ecpt_state_t st_q, st_d;

    logic        addr_ok;
    logic        wr_ctl0, wr_ctl1, wr_ioc2, wr_opt0, wr_ccr0, wr_ccr1;
    logic        ev_edge, tr_edge, trig, tick;

    assign addr_ok = hsel & hready & htrans[1];

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        wr_pend_d = addr_ok & hwrite;
        wr_addr_d = addr_ok ? haddr : wr_addr_q;
        wr_ctl0   = wr_pend_q && wr_addr_q == `ECPT_CTL0_OFS;
        wr_ctl1   = wr_pend_q && wr_addr_q == `ECPT_CTL1_OFS;
        wr_ioc2   = wr_pend_q && wr_addr_q == `ECPT_IOC2_OFS;
        wr_opt0   = wr_pend_q && wr_addr_q == `ECPT_OPT0_OFS;
        wr_ccr0   = wr_pend_q && wr_addr_q == `ECPT_CCR0_OFS;
        wr_ccr1   = wr_pend_q && wr_addr_q == `ECPT_CCR1_OFS;
        ce_d      = wr_ctl0 ? hwdata[`ECPT_CE_BIT] : ce_q;
        mode_d    = wr_ctl1 ? hwdata[2:0] : mode_q;
        eee_d     = wr_ctl1 ? hwdata[`ECPT_EEE_BIT] : eee_q;
        swtrig_d  = wr_ctl1 & hwdata[`ECPT_EST_BIT];                 // [RULE13]
        ioc2_d    = wr_ioc2 ? (hwdata[7:0] & `ECPT_IOC2_MASK) : ioc2_q; // [RULE24]
        ccr0_d    = wr_ccr0 ? hwdata[15:0] : ccr0_q;
        ccr1_d    = wr_ccr1 ? hwdata[15:0] : ccr1_q;
        hrdata_d  = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr)
                `ECPT_CTL0_OFS: hrdata_d = {31'h0, ce_q};
                `ECPT_CTL1_OFS: hrdata_d = {26'h0, eee_q, 2'h0, mode_q};
                `ECPT_IOC2_OFS: hrdata_d = {24'h0, ioc2_q};
                `ECPT_OPT0_OFS: hrdata_d = {31'h0, ovf_q};
                `ECPT_CCR0_OFS: hrdata_d = {16'h0, ccr0_q};
                `ECPT_CCR1_OFS: hrdata_d = {16'h0, ccr1_q};
                `ECPT_CNT_OFS:  hrdata_d = {16'h0, cnt_q};              // [RULE25]
                `ECPT_STAT_OFS: hrdata_d = {29'h0, st_q};
                default:        hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Counter and outputs
    // ----------------------------------------
    always_comb begin
        evt_d    = event_in;
        trg_d    = trigger_in;
        ev_edge  = edge_hit(ioc2_q[3:2], event_in, evt_q);
        tr_edge  = edge_hit(ioc2_q[1:0], trigger_in, trg_q);
        trig     = tr_edge | swtrig_q;                                  // [RULE13]
        // Event mode or event clock select counts edges, otherwise every clock
        tick     = (mode_q == `ECPT_MODE_EVENT || eee_q) ? ev_edge : 1'b1; // [RULE1]
        st_d     = st_q;
        cnt_d    = cnt_q;
        buf0_d   = buf0_q;
        buf1_d   = buf1_q;
        reload_d = reload_q | wr_ccr1;                                  // [RULE17]
        ovf_d    = wr_opt0 ? hwdata[`ECPT_OVF_BIT] : ovf_q;
        to0_d    = to0_q;
        to1_d    = to1_q;
        irq0_d   = 1'b0;
        irq1_d   = 1'b0;
        if (!ce_q) begin
            st_d      = ecpt_pkg::ECPT_IDLE;
            cnt_d     = `ECPT_CNT_MAX;
            to0_d     = 1'b0;
            to1_d     = 1'b0;
            buf0_d    = ccr0_q;
            buf1_d    = ccr1_q;
            reload_d  = 1'b0;
        end else begin
            case (st_q)
                ecpt_pkg::ECPT_IDLE: begin
                    buf0_d = ccr0_q;
                    buf1_d = ccr1_q;
                    if (mode_q == `ECPT_MODE_TRIG) begin
                        st_d = ecpt_pkg::ECPT_WAIT;                     // [RULE9]
                    end else if (tick) begin
                        // Start clears FFFFH to zero
                        cnt_d = `ECPT_CNT_ZERO;
                        st_d  = ecpt_pkg::ECPT_RUN;
                        if (mode_q == `ECPT_MODE_INTV) begin
                            to0_d = ~to0_q;
                        end
                    end
                end
                ecpt_pkg::ECPT_WAIT: begin
                    if (trig) begin
                        cnt_d  = `ECPT_CNT_ZERO;                        // [RULE11]
                        st_d   = ecpt_pkg::ECPT_RUN;
                        to0_d  = ~to0_q;                                // [RULE15]
                        to1_d  = ccr1_q != `ECPT_CCR_RST;               // [RULE20]
                        buf0_d = ccr0_q;
                        buf1_d = ccr1_q;
                    end
                end
                ecpt_pkg::ECPT_RUN: begin
                    if (mode_q == `ECPT_MODE_EVENT && wr_ccr0) begin
                        buf0_d = hwdata[15:0];                          // [RULE6]
                    end
                    if (mode_q == `ECPT_MODE_TRIG && trig) begin
                        // Restart wins over any match in this cycle
                        cnt_d     = `ECPT_CNT_ZERO;                     // [RULE12] [RULE22]
                        to0_d     = ~to0_q;                             // [RULE12] [RULE15]
                        to1_d     = buf1_q != `ECPT_CCR_RST;            // [RULE23] [RULE20]
                    end else if (tick) begin
                        if (cnt_q == buf0_q) begin
                            // Clear on the count after the match, so period is compare plus one
                            cnt_d  = `ECPT_CNT_ZERO;                    // [RULE2] [RULE5]
                            irq0_d = 1'b1;                              // [RULE16]
                            if (mode_q == `ECPT_MODE_INTV) begin
                                to0_d = ~to0_q;
                            end
                            if (mode_q == `ECPT_MODE_TRIG) begin
                                to0_d = ~to0_q;                         // [RULE15]
                                to1_d = 1'b1;
                                if (reload_q) begin
                                    buf0_d   = ccr0_q;                  // [RULE17]
                                    buf1_d   = ccr1_q;
                                    reload_d = wr_ccr1;
                                end
                            end
                        end else begin
                            // Wrap past FFFFH is a genuine overflow
                            cnt_d = cnt_q + 16'h0001;                   // [RULE6]
                            if (cnt_q == `ECPT_CNT_MAX) begin
                                ovf_d = 1'b1;
                            end
                        end
                        if (mode_q == `ECPT_MODE_TRIG) begin
                            // Fires as the count reaches it, with the output edge
                            if (cnt_d == buf1_d) begin
                                irq1_d = 1'b1;                          // [RULE16] [RULE20]
                                to1_d  = 1'b0;                          // [RULE14] [RULE21]
                            end
                        end else if (cnt_q == buf1_q) begin
                            irq1_d = 1'b1;                              // [RULE8]
                        end
                    end
                end
                default: st_d = ecpt_pkg::ECPT_IDLE;
            endcase
        end
        // Outputs unavailable in event mode
        if (mode_q == `ECPT_MODE_EVENT) begin
            to0_d = 1'b0;                                               // [RULE4]
            to1_d = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
            ce_q      <= 1'b0;
            mode_q    <= 3'h0;
            eee_q     <= 1'b0;
            ioc2_q    <= 8'h00;
            ovf_q     <= 1'b0;
            ccr0_q    <= `ECPT_CCR_RST;
            ccr1_q    <= `ECPT_CCR_RST;
            buf0_q    <= `ECPT_CCR_RST;
            buf1_q    <= `ECPT_CCR_RST;
            reload_q  <= 1'b0;
            swtrig_q  <= 1'b0;
            cnt_q     <= `ECPT_CNT_MAX;
            evt_q     <= 1'b0;
            trg_q     <= 1'b0;
            to0_q     <= 1'b0;
            to1_q     <= 1'b0;
            irq0_q    <= 1'b0;
            irq1_q    <= 1'b0;
            st_q      <= ecpt_pkg::ECPT_IDLE;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
            ce_q      <= ce_d;
            mode_q    <= mode_d;
            eee_q     <= eee_d;
            ioc2_q    <= ioc2_d;
            ovf_q     <= ovf_d;
            ccr0_q    <= ccr0_d;
            ccr1_q    <= ccr1_d;
            buf0_q    <= buf0_d;
            buf1_q    <= buf1_d;
            reload_q  <= reload_d;
            swtrig_q  <= swtrig_d;
            cnt_q     <= cnt_d;
            evt_q     <= evt_d;
            trg_q     <= trg_d;
            to0_q     <= to0_d;
            to1_q     <= to1_d;
            irq0_q    <= irq0_d;
            irq1_q    <= irq1_d;
            st_q      <= st_d;
        end
    end

    assign hrdata            = hrdata_q;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign timer_output_zero = to0_q;
    assign timer_output_one  = to1_q;
    assign match_zero_irq    = irq0_q;
    assign match_one_irq     = irq1_q;

endmodule : ecpt_timer
`default_nettype wire

/* verif/ecpt_sources.sv */
`default_nettype none
module ecpt_sources (
    // Clock and pins
    input wire logic hclk,
    output logic     event_in,
    output logic     trigger_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        event_in = 1'b0;
        trigger_in = 1'b0;
    end
    // Two cycles per level so the one-clock edge detector never misses one
    task automatic events(input int n);
        repeat (n) begin
            event_in <= 1'b1;
            repeat (2) @(posedge hclk);
            event_in <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask : events
    task automatic trigger;
        trigger_in <= 1'b1;
        repeat (2) @(posedge hclk);
        trigger_in <= 1'b0;
        @(posedge hclk);
    endtask : trigger
endmodule : ecpt_sources
`default_nettype wire

/* verif/ecpt_timer_bench.sv */
`include "ecpt_consts.svh"
`default_nettype none
module ecpt_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic        hreadyout, hresp, event_in, trigger_in;
    logic        timer_output_zero, timer_output_one, match_zero_irq, match_one_irq;
    int          miscompares = 0, total_checks = 0, irq0_cnt = 0, irq1_cnt = 0;
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (match_zero_irq === 1'b1) irq0_cnt++;
        if (match_one_irq === 1'b1) irq1_cnt++;
    end
    ecpt_sources src (.hclk(hclk), .event_in(event_in), .trigger_in(trigger_in));
    ecpt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .event_in(event_in), .trigger_in(trigger_in), .timer_output_zero(timer_output_zero),
        .timer_output_one(timer_output_one), .match_zero_irq(match_zero_irq),
        .match_one_irq(match_one_irq));
    // ----------
    // Bus and compare tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(what, exp, x);
    endtask : rdc
    task automatic wait_irq0;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (match_zero_irq !== 1'b1 && n < 200);
        if (n >= 200) chk("irq0 wait", 32'h1, 32'h0);
    endtask : wait_irq0
    // Window runs irq0 to irq0, so output skew against irq0 cancels out
    task automatic measure(input logic [31:0] hi, input logic [31:0] ones);
        int n, h, k;
        logic t0;
        wait_irq0();
        {n, h, k} = '0;
        t0 = timer_output_zero;
        do begin
            @(posedge hclk);
            n++;
            if (timer_output_one === 1'b1) h++;
            if (match_one_irq === 1'b1) k++;
        end while (match_zero_irq !== 1'b1 && n < 200);
        chk("period", 32'd10, 32'(n));
        chk("active width", hi, 32'(h));
        chk("output zero", {31'h0, ~t0}, {31'h0, timer_output_zero});
        if (ones != 32'hffffffff) chk("irq1 count", ones, 32'(k));
    endtask : measure
    // ----------
    // Scenarios
    // ----------
    task automatic regs_test;
        for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0, "reset value");
        rdc(8'h20, 32'h0, "unmapped");
        wr(`ECPT_CNT_OFS, 32'h00001234);
        rdc(`ECPT_CNT_OFS, 32'h0000ffff, "counter readback");
        wr(`ECPT_IOC2_OFS, 32'h000000ff);
        rdc(`ECPT_IOC2_OFS, 32'h0000000f, "edge select");
        wr(`ECPT_IOC2_OFS, 32'h00000005);
    endtask : regs_test
    task automatic event_test;
        wr(`ECPT_CTL1_OFS, 32'h1);
        wr(`ECPT_CCR0_OFS, 32'h3);
        wr(`ECPT_CCR1_OFS, 32'h1);
        wr(`ECPT_CTL0_OFS, 32'h1);
        src.events(2);
        // First edge only takes the counter from FFFFH to zero
        rdc(`ECPT_CNT_OFS, 32'h1, "event count");
        src.events(1);
        chk("early irq0", 32'h0, 32'(irq0_cnt));
        src.events(6);
        repeat (4) @(posedge hclk);
        chk("irq0 count", 32'd2, 32'(irq0_cnt));
        chk("irq1 count", 32'd2, 32'(irq1_cnt));
        chk("outputs", 32'h0, {30'h0, timer_output_zero, timer_output_one});
        wr(`ECPT_CTL0_OFS, 32'h0);
    endtask : event_test
    task automatic pwm_test;
        logic [31:0] duty [3] = '{32'd7, 32'd0, 32'd10};
        wr(`ECPT_CTL1_OFS, 32'h2);
        wr(`ECPT_CCR0_OFS, 32'h9);
        wr(`ECPT_CCR1_OFS, 32'h4);
        wr(`ECPT_CTL0_OFS, 32'h1);
        // State moves one clock after enable lands
        @(posedge hclk);
        rdc(`ECPT_STAT_OFS, 32'h2, "waiting");
        wr(`ECPT_CTL1_OFS, 32'h42);
        measure(32'd4, 32'd1);
        for (int i = 0; i < 3; i++) begin
            wr(`ECPT_CCR1_OFS, duty[i]);
            wait_irq0();
            measure(duty[i], 32'hffffffff);
        end
        wr(`ECPT_CCR0_OFS, 32'h5);
        wait_irq0();
        measure(32'd10, 32'hffffffff);
        wr(`ECPT_CCR0_OFS, 32'h9);
    endtask : pwm_test
    task automatic retrigger_test;
        int n;
        logic t0;
        wr(`ECPT_CCR1_OFS, 32'h4);
        wait_irq0();
        wait_irq0();
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (match_one_irq !== 1'b1 && n < 50);
        t0 = timer_output_zero;
        src.trigger();
        @(posedge hclk);
        chk("output one", 32'h1, {31'h0, timer_output_one});
        chk("output zero", {31'h0, ~t0}, {31'h0, timer_output_zero});
    endtask : retrigger_test
    task automatic results;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        regs_test();
        event_test();
        pwm_test();
        retrigger_test();
        results();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule : ecpt_timer_bench
bind ecpt_timer ecpt_timer_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_output_zero(timer_output_zero), .timer_output_one(timer_output_one),
    .match_zero_irq(match_zero_irq), .match_one_irq(match_one_irq));
`default_nettype wire

/* verif/ecpt_timer_monitor.sv */
`include "ecpt_consts.svh"
`default_nettype none
module ecpt_timer_monitor (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire logic        timer_output_zero,
    input wire logic        timer_output_one,
    input wire logic        match_zero_irq,
    input wire logic        match_one_irq
);
    // ----------
    // Shadow of mode and enable, rebuilt from bus writes
    // ----------
    logic       wp_q, wp_d, rp_q, rp_d, ce_q, ce_d;
    logic [7:0] adr_q, adr_d;
    logic [2:0] mode_q, mode_d;
    always_comb begin
        wp_d = hsel & hready & htrans[1] & hwrite;
        rp_d = hsel & hready & htrans[1] & ~hwrite;
        adr_d = haddr;
        mode_d = mode_q;
        ce_d = ce_q;
        if (wp_q && adr_q == `ECPT_CTL1_OFS) mode_d = hwdata[2:0];
        if (wp_q && adr_q == `ECPT_CTL0_OFS) ce_d = hwdata[`ECPT_CE_BIT];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wp_q, rp_q, ce_q, adr_q, mode_q} <= '0;
        end else begin
            {wp_q, rp_q, ce_q, adr_q, mode_q} <= {wp_d, rp_d, ce_d, adr_d, mode_d};
        end
    end
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_const_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
    resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
    rdata_idle_a: assert property (!rp_q |-> hrdata == 32'h0) else $error("hrdata not idle");
    irq0_pulse_a: assert property (match_zero_irq |=> !match_zero_irq)
        else $error("irq0 longer than a cycle");
    irq1_pulse_a: assert property (match_one_irq |=> !match_one_irq)
        else $error("irq1 longer than a cycle");
    event_quiet_a: assert property ((mode_q == `ECPT_MODE_EVENT &&
        $past(mode_q) == `ECPT_MODE_EVENT) |-> $stable({timer_output_zero, timer_output_one}))
        else $error("output moved in event mode");
    pwm_fall_a: assert property ((mode_q == `ECPT_MODE_TRIG && ce_q &&
        $fell(timer_output_one)) |-> match_one_irq) else $error("output one fell without irq1");
    stop_silent_a: assert property ((!ce_q && !$past(ce_q) && !$past(ce_q, 2))
        |-> !(match_zero_irq || match_one_irq)) else $error("irq while stopped");
    cover property (match_zero_irq && mode_q == `ECPT_MODE_EVENT);
    cover property (match_one_irq && mode_q == `ECPT_MODE_TRIG);
    cover property ($rose(timer_output_one));
endmodule : ecpt_timer_monitor
`default_nettype wire
